/* rtl/iaf_params.svh */
// Constants of the in-application flash erase/write controller
`ifndef IAF_PARAMS_SVH
`define IAF_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IAF_OFS_CTRL  8'h00
`define IAF_OFS_BUFC  8'h04
`define IAF_OFS_ADRL  8'h08
`define IAF_OFS_ADRH  8'h0C
`define IAF_OFS_DLO   8'h10
`define IAF_OFS_DHI   8'h14
`define IAF_OFS_KEY0  8'h18
`define IAF_KEY_STEP  8'h04
// ----------------------------------------
// Field positions
// ----------------------------------------
`define IAF_B_UNLK    7
`define IAF_B_MODE_HI 6
`define IAF_B_MODE_LO 4
`define IAF_B_UTRIG   3
`define IAF_B_PTRIG   2
`define IAF_B_RSV7    7
`define IAF_B_RSV4    4
`define IAF_B_CLR     0
`define IAF_PG_LSB    5
`define IAF_AW        12
// ----------------------------------------
// Codes and values
// ----------------------------------------
`define IAF_MODE_WRITE  3'h0
`define IAF_MODE_ERASE  3'h1
`define IAF_MODE_UNLOCK 3'h6
`define IAF_WORD_LAST   5'h1F
`define IAF_KEY_L1 8'h00
`define IAF_KEY_H1 8'h04
`define IAF_KEY_L2 8'h0D
`define IAF_KEY_H2 8'h09
`define IAF_KEY_L3 8'hC3
`define IAF_KEY_H3 8'h40
`define IAF_RESP_OKAY   2'h0
`define IAF_RESP_SLVERR 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define IAF_CLK_MHZ     20
`define IAF_WIN_TIME_US 1000
`define IAF_OP_TIME_US  2200
`define IAF_WIN_CYC (`IAF_WIN_TIME_US * `IAF_CLK_MHZ)
`define IAF_OP_CYC  (`IAF_OP_TIME_US * `IAF_CLK_MHZ)
`endif

/* rtl/iaf_pkg.sv */
// Types of the in-application flash erase/write controller
package iaf_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} iaf_state_type;
endpackage

/* rtl/iaf_flash_ctrl.sv */
// AXI4-Lite in-application flash erase/write controller
`timescale 1ns/1ns
`include "iaf_params.svh"
// Operation
// - Clear request bit clears buffer, self-clears
// - Buffer control bits 6:5 and 3:1 read zero; reserved bits 7 and 4 read back
// - Good unlock sets unlocked status bit
// - Unlock trigger starts window timer
// - Six key bytes compared against pattern
// - Window expiry clears unlock trigger always
// - Wrong key leaves erase/write locked
// - Clearing unlocked bit relocks at once, except while an open window still holds the good key
// - Buffer holds 32 words, page from bit 5
// - High byte load advances buffer address
// - Buffer address saturates at page end
// - Mode 001 trigger erases page
// - Mode 000 trigger writes buffer
// - CPU halted while operation runs
// - Program trigger stays high 2.2 ms
// - High byte write loads whole word
// - Low byte write loads nothing
// - Software cannot set unlocked bit
module iaf_flash_ctrl #(
   parameter int WIN_CYCLES = `IAF_WIN_CYC,
   parameter int OP_CYCLES  = `IAF_OP_CYC
)(
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic                     cpu_stall,
   output logic                     flash_erase,
   output logic [6:0]               flash_page,
   output logic                     flash_wr,
   output logic [`IAF_AW-1:0]       flash_wr_addr,
   output logic [15:0]              flash_wr_data
);
   localparam logic [15:0] WIN_LAST = 16'(WIN_CYCLES - 1);
   localparam logic [15:0] OP_LAST  = 16'(OP_CYCLES - 1);
   localparam logic [7:0]  KEY_PAT [6] = '{`IAF_KEY_L1, `IAF_KEY_H1, `IAF_KEY_L2,
                                           `IAF_KEY_H2, `IAF_KEY_L3, `IAF_KEY_H3};
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic                 awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [7:0]           awaddr_ff;
   logic [7:0]           wdata_ff;
   logic                 wstrb_ff;
   logic [1:0]           bresp_ff, rresp_ff;
   logic [31:0]          rdata_ff;
   logic                 unlocked_ff, utrig_ff, ptrig_ff, clr_ff, rsv7_ff, rsv4_ff;
   logic [2:0]           mode_ff;
   logic [`IAF_AW-1:0]   addr_ff;
   logic [7:0]           dlo_ff, dhi_ff;
   logic [7:0]           key_ff [6];
   logic [15:0]          buf_ff [32];
   logic [31:0]          loaded_ff;
   logic [15:0]          win_cnt_ff, op_cnt_ff;
   logic [5:0]           emit_ff;
   iaf_pkg::iaf_state_type state_ff, nxt_state;
   logic                 stall_ff, erase_ff, fwr_ff;
   logic [6:0]           page_ff;
   logic [`IAF_AW-1:0]   fwa_ff;
   logic [15:0]          fwd_ff;
   // ----------------------------------------
   // Write decode
   // ----------------------------------------
   wire       wr_go   = !awready_ff && !wready_ff && !bvalid_ff;
   wire       we      = wr_go && wstrb_ff;
   wire [2:0] wmode   = wdata_ff[`IAF_B_MODE_HI:`IAF_B_MODE_LO];
   wire       sel_ctl = awaddr_ff == `IAF_OFS_CTRL;
   wire       sel_frc = awaddr_ff == `IAF_OFS_BUFC;
   wire       sel_al  = awaddr_ff == `IAF_OFS_ADRL;
   wire       sel_ah  = awaddr_ff == `IAF_OFS_ADRH;
   wire       sel_dlo = awaddr_ff == `IAF_OFS_DLO;
   wire       sel_dhi = awaddr_ff == `IAF_OFS_DHI;
   wire [5:0] sel_key;
   wire [5:0] key_hit;
   wire       wr_map  = sel_ctl || sel_frc || sel_al || sel_ah || sel_dlo || sel_dhi
                        || (|sel_key);
   wire       ctl_we  = we && sel_ctl;
   wire       load_we = we && sel_dhi;
   wire       idle    = state_ff == iaf_pkg::ST_IDLE;
   wire       key_ok  = &key_hit;
   wire       ustart  = ctl_we && wdata_ff[`IAF_B_UTRIG] && wmode == `IAF_MODE_UNLOCK
                        && !utrig_ff;
   wire       win_end = utrig_ff && win_cnt_ff == WIN_LAST;
   wire       unl_set = utrig_ff && key_ok;
   wire       pstart  = ctl_we && wdata_ff[`IAF_B_PTRIG] && unlocked_ff
                        && wdata_ff[`IAF_B_UNLK] && idle
                        && (wmode == `IAF_MODE_ERASE || wmode == `IAF_MODE_WRITE);
   wire       op_end  = !idle && op_cnt_ff == OP_LAST;
   wire       buf_clr = clr_ff || (op_end && state_ff == iaf_pkg::ST_WRITE);
   wire       at_last = addr_ff[`IAF_PG_LSB-1:0] == `IAF_WORD_LAST;
   wire [4:0] widx    = addr_ff[`IAF_PG_LSB-1:0];
   // ----------------------------------------
   // AXI4-Lite handshakes
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `IAF_RESP_OKAY;
         awaddr_ff  <= 8'h00;
         wdata_ff   <= 8'h00;
         wstrb_ff   <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && awready_ff)
         begin
            awaddr_ff  <= s_axi_awaddr;
            awready_ff <= 1'b0;
         end
         if (s_axi_wvalid && wready_ff)
         begin
            wdata_ff  <= s_axi_wdata[7:0];
            wstrb_ff  <= s_axi_wstrb[0];
            wready_ff <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_map ? `IAF_RESP_OKAY : `IAF_RESP_SLVERR;
         end
         if (bvalid_ff && s_axi_bready)
         begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end
   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [7:0] rd_val;
   logic       rd_ok;
   always_comb
   begin
      rd_val = 8'h00;
      rd_ok  = 1'b1;
      unique case (s_axi_araddr)
         `IAF_OFS_CTRL: rd_val = {unlocked_ff, mode_ff, utrig_ff, ptrig_ff, 2'h0};
         `IAF_OFS_BUFC: rd_val = {rsv7_ff, 2'h0, rsv4_ff, 3'h0, clr_ff};
         `IAF_OFS_ADRL: rd_val = addr_ff[7:0];
         `IAF_OFS_ADRH: rd_val = {4'h0, addr_ff[`IAF_AW-1:8]};
         `IAF_OFS_DLO:  rd_val = dlo_ff;
         `IAF_OFS_DHI:  rd_val = dhi_ff;
         default:
         begin
            rd_ok = 1'b0;
            for (int k = 0; k < 6; k++)
            begin
               if (s_axi_araddr == 8'(`IAF_OFS_KEY0 + k * `IAF_KEY_STEP))
               begin
                  rd_val = key_ff[k];
                  rd_ok  = 1'b1;
               end
            end
         end
      endcase
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `IAF_RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_ff)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= {24'h000000, rd_val};
         rresp_ff   <= rd_ok ? `IAF_RESP_OKAY : `IAF_RESP_SLVERR;
      end
      else if (rvalid_ff && s_axi_rready)
      begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
      end
   end
   // ----------------------------------------
   // Key registers
   // ----------------------------------------
   for (genvar k = 0; k < 6; k++)
   begin : g_key
      assign sel_key[k] = awaddr_ff == 8'(`IAF_OFS_KEY0 + k * `IAF_KEY_STEP);
      assign key_hit[k] = key_ff[k] == KEY_PAT[k];
      always_ff @(posedge aclk)
      begin
         // Wiped on trigger so stale keys cannot unlock a new window
         if (!aresetn || ustart)
            key_ff[k] <= 8'h00;
         else if (we && sel_key[k])
            key_ff[k] <= wdata_ff;
      end
   end
   // ----------------------------------------
   // Control and unlock
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         unlocked_ff <= 1'b0;
         mode_ff     <= 3'h0;
         utrig_ff    <= 1'b0;
         ptrig_ff    <= 1'b0;
         win_cnt_ff  <= 16'h0000;
         clr_ff      <= 1'b0;
         rsv7_ff     <= 1'b0;
         rsv4_ff     <= 1'b0;
      end
      else
      begin
         if (unl_set)
            unlocked_ff <= 1'b1;
         else if (ctl_we && !wdata_ff[`IAF_B_UNLK])
            unlocked_ff <= 1'b0;
         if (ctl_we && idle)
            mode_ff <= wmode;
         if (ustart)
            utrig_ff <= 1'b1;
         else if (win_end)
            utrig_ff <= 1'b0;
         // Back to zero at expiry so the next window starts clean
         win_cnt_ff <= (utrig_ff && !win_end) ? win_cnt_ff + 16'h0001 : 16'h0000;
         if (pstart)
            ptrig_ff <= 1'b1;
         else if (op_end)
            ptrig_ff <= 1'b0;
         if (we && sel_frc && wdata_ff[`IAF_B_CLR])
            clr_ff <= 1'b1;
         else if (clr_ff)
            clr_ff <= 1'b0;
         if (we && sel_frc)
         begin
            rsv7_ff <= wdata_ff[`IAF_B_RSV7];
            rsv4_ff <= wdata_ff[`IAF_B_RSV4];
         end
      end
   end
   // ----------------------------------------
   // Address and data staging
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         addr_ff <= '0;
         dlo_ff  <= 8'h00;
         dhi_ff  <= 8'h00;
      end
      else
      begin
         if (we && sel_al)
            addr_ff[7:0] <= wdata_ff;
         if (we && sel_ah)
            addr_ff[`IAF_AW-1:8] <= wdata_ff[`IAF_AW-9:0];
         if (load_we && !at_last)
            addr_ff <= addr_ff + `IAF_AW'(1);
         if (we && sel_dlo)
            dlo_ff <= wdata_ff;
         if (load_we)
            dhi_ff <= wdata_ff;
      end
   end
   // ----------------------------------------
   // Page write buffer
   // ----------------------------------------
   // A load in the clear cycle survives; software may refill at once
   for (genvar i = 0; i < 32; i++)
   begin : g_buf
      always_ff @(posedge aclk)
      begin
         if (!aresetn)
         begin
            buf_ff[i]    <= 16'h0000;
            loaded_ff[i] <= 1'b0;
         end
         else if (load_we && widx == 5'(i))
         begin
            buf_ff[i]    <= {wdata_ff, dlo_ff};
            loaded_ff[i] <= 1'b1;
         end
         else if (buf_clr)
         begin
            buf_ff[i]    <= 16'h0000;
            loaded_ff[i] <= 1'b0;
         end
      end
   end
   // ----------------------------------------
   // Operation sequencer
   // ----------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         iaf_pkg::ST_IDLE:
            if (pstart)
               nxt_state = (wmode == `IAF_MODE_ERASE) ? iaf_pkg::ST_ERASE
                                                      : iaf_pkg::ST_WRITE;
         iaf_pkg::ST_ERASE,
         iaf_pkg::ST_WRITE:
            if (op_end)
               nxt_state = iaf_pkg::ST_IDLE;
      endcase
   end
   wire emit_on = state_ff == iaf_pkg::ST_WRITE && !emit_ff[5];
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_ff  <= iaf_pkg::ST_IDLE;
         op_cnt_ff <= 16'h0000;
         emit_ff   <= 6'h00;
         stall_ff  <= 1'b0;
         erase_ff  <= 1'b0;
         page_ff   <= 7'h00;
         fwr_ff    <= 1'b0;
         fwa_ff    <= '0;
         fwd_ff    <= 16'h0000;
      end
      else
      begin
         state_ff  <= nxt_state;
         op_cnt_ff <= idle ? 16'h0000 : op_cnt_ff + 16'h0001;
         emit_ff   <= emit_on ? emit_ff + 6'h01 : (idle ? 6'h00 : emit_ff);
         stall_ff  <= nxt_state != iaf_pkg::ST_IDLE;
         erase_ff  <= pstart && wmode == `IAF_MODE_ERASE;
         if (pstart)
            page_ff <= addr_ff[`IAF_AW-1:`IAF_PG_LSB];
         // Only loaded words reach flash, unloaded cells keep their value
         fwr_ff <= emit_on && loaded_ff[emit_ff[4:0]];
         fwa_ff <= {page_ff, emit_ff[4:0]};
         fwd_ff <= buf_ff[emit_ff[4:0]];
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign cpu_stall     = stall_ff;
   assign flash_erase   = erase_ff;
   assign flash_page    = page_ff;
   assign flash_wr      = fwr_ff;
   assign flash_wr_addr = fwa_ff;
   assign flash_wr_data = fwd_ff;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_op_start;
      pstart;
   endsequence
   sequence s_busy;
      (stall_ff && ptrig_ff)[*8];
   endsequence
   a_unlock_on_key: assert property (unl_set |=> unlocked_ff)
      else $error("unlock not set on good key");
   a_hw_only_set: assert property ($rose(unlocked_ff) |-> $past(unl_set))
      else $error("unlocked bit set without key");
   a_relock_now: assert property (ctl_we && !wdata_ff[`IAF_B_UNLK] && !unl_set
      |=> !unlocked_ff)
      else $error("relock did not take");
   a_window_end: assert property (win_end |=> !utrig_ff && win_cnt_ff == 16'h0000)
      else $error("unlock trigger outlived window");
   a_window_start: assert property (ustart |=> utrig_ff ##1 win_cnt_ff == 16'h0001)
      else $error("window timer did not start");
   a_locked_idle: assert property (!unlocked_ff && idle |=> !ptrig_ff)
      else $error("operation started while locked");
   a_op_busy: assert property (s_op_start |=> s_busy)
      else $error("stall or trigger dropped early");
   a_op_done: assert property (op_end |=> !ptrig_ff && !stall_ff)
      else $error("trigger did not fall at end");
   a_clear_done: assert property (clr_ff && !load_we |=> loaded_ff == 32'h0000_0000)
      else $error("buffer clear incomplete");
   a_addr_incr: assert property (load_we && !at_last
      |=> addr_ff == $past(addr_ff) + `IAF_AW'(1))
      else $error("buffer address did not advance");
   a_addr_sat: assert property (load_we && at_last |=> addr_ff == $past(addr_ff))
      else $error("buffer address passed page end");
   a_low_noload: assert property (we && sel_dlo && !buf_clr
      |=> loaded_ff == $past(loaded_ff))
      else $error("low byte loaded the buffer");
   a_rsv_zero: assert property (s_axi_arvalid && arready_ff && s_axi_araddr == `IAF_OFS_BUFC
      |=> rdata_ff[6:5] == 2'h0 && rdata_ff[3:1] == 3'h0)
      else $error("unused read bits not zero");
endmodule

/* tb/iap_flash_erase_write_ctrl_bench.sv */
// Self-checking bench of the in-application flash erase/write controller
`timescale 1ns/1ns
`include "iaf_params.svh"
module iap_flash_erase_write_ctrl_bench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   // Short window so a correct key still lands inside it
   localparam int WIN = 100;
   localparam int OPC = 40;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic        cpu_stall;
   logic        flash_erase;
   logic [6:0]  flash_page;
   logic        flash_wr;
   logic [11:0] flash_wr_addr;
   logic [15:0] flash_wr_data;
   int          mismatches = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          run = 0;
   logic [33:0] rd_q[$];
   logic [1:0]  b_q[$];
   logic [6:0]  er_q[$];
   logic [27:0] fw_q[$];
   logic [7:0]  key_pat[6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};

   iaf_flash_ctrl #(.WIN_CYCLES(WIN), .OP_CYCLES(OPC)) dut (
      .aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .cpu_stall, .flash_erase, .flash_page,
      .flash_wr, .flash_wr_addr, .flash_wr_data
   );

   initial
   begin
      forever #25 aclk = ~aclk;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_of_test;
      if (mismatches == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r = 2'h0, input logic [3:0] s = 4'hF);
      b_q.push_back(r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!s_axi_awready);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!s_axi_wready);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
      rd_q.push_back({r, 24'h0, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Mode 110 plus trigger, then six key bytes; last one chosen by caller
   task automatic unlock(input logic [7:0] last);
      wr(`IAF_OFS_CTRL, 8'h68);
      for (int i = 0; i < 6; i++)
         wr(8'h18 + 8'(4 * i), (i == 5) ? last : key_pat[i]);
   endtask

   task automatic load(input logic [15:0] w);
      wr(`IAF_OFS_DLO, w[7:0]);
      wr(`IAF_OFS_DHI, w[15:8]);
   endtask

   // Trigger, see trigger bit high mid-run, then low once stall ends
   // A hang here is ended by the bench timeout
   task automatic op(input logic [7:0] cmd);
      wr(`IAF_OFS_CTRL, cmd);
      rd(`IAF_OFS_CTRL, cmd);
      while (cpu_stall)
         @(posedge aclk);
      @(posedge aclk);
      rd(`IAF_OFS_CTRL, cmd & 8'hFB);
   endtask

   // ----------------------------------------
   // Output watcher
   // ----------------------------------------
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         chk("read", 48'(rd_q.pop_front()), {14'h0, s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready)
         chk("bresp", 48'(b_q.pop_front()), 48'(s_axi_bresp));
      if (flash_erase)
         chk("page", 48'(er_q.pop_front()), 48'(flash_page));
      if (flash_wr)
         chk("word", 48'(fw_q.pop_front()), {20'h0, flash_wr_addr, flash_wr_data});
      if (flash_wr || flash_erase)
         chk("stall", 48'h1, 48'(cpu_stall));
      if (cpu_stall)
         run++;
      else if (run != 0)
      begin
         chk("stall_len", 48'(OPC), 48'(run));
         run = 0;
      end
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      logic [6:0]  pg;
      logic [15:0] w[32];
      int          n;
      void'($urandom(32'h55CC));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 12; i++)
         rd(8'(4 * i), 8'h00);
      rd(8'h30, 8'h00, `IAF_RESP_SLVERR);
      wr(8'h30, 8'h5A, `IAF_RESP_SLVERR);
      wr(`IAF_OFS_ADRL, 8'hFF, 2'h0, 4'h0);
      rd(`IAF_OFS_ADRL, 8'h00);
      wr(`IAF_OFS_BUFC, 8'h2E);
      rd(`IAF_OFS_BUFC, 8'h00);
      wr(`IAF_OFS_BUFC, 8'h01);
      rd(`IAF_OFS_BUFC, 8'h00);
      // Locked: set attempt and erase trigger both ignored
      wr(`IAF_OFS_CTRL, 8'h94);
      repeat (5) @(posedge aclk);
      rd(`IAF_OFS_CTRL, 8'h10);
      unlock(8'h41);
      repeat (WIN) @(posedge aclk);
      rd(`IAF_OFS_CTRL, 8'h60);
      unlock(8'h40);
      rd(`IAF_OFS_CTRL, 8'hE8);
      repeat (WIN) @(posedge aclk);
      rd(`IAF_OFS_CTRL, 8'hE0);
      pg = 7'($urandom);
      wr(`IAF_OFS_ADRL, {pg[2:0], 5'h00});
      wr(`IAF_OFS_ADRH, {4'h0, pg[6:3]});
      er_q.push_back(pg);
      op(8'h94);
      n = 1 + ($urandom % 32);
      for (int i = 0; i < n; i++)
      begin
         w[i] = 16'($urandom);
         load(w[i]);
         fw_q.push_back({pg, 5'(i), w[i]});
      end
      rd(`IAF_OFS_ADRL, {pg[2:0], (n == 32) ? 5'h1F : 5'(n)});
      op(8'h84);
      // Fill the page tail past its end, then clear before writing
      wr(`IAF_OFS_ADRL, {pg[2:0], 5'h1D});
      for (int i = 0; i < 4; i++)
         load(w[0]);
      rd(`IAF_OFS_ADRL, {pg[2:0], 5'h1F});
      wr(`IAF_OFS_DLO, 8'hA5);
      rd(`IAF_OFS_ADRL, {pg[2:0], 5'h1F});
      wr(`IAF_OFS_BUFC, 8'h01);
      wr(`IAF_OFS_DHI, 8'h3C);
      fw_q.push_back({pg, 5'h1F, 16'h3CA5});
      op(8'h84);
      wr(`IAF_OFS_CTRL, 8'h00);
      rd(`IAF_OFS_CTRL, 8'h00);
      wr(`IAF_OFS_CTRL, 8'h84);
      repeat (5) @(posedge aclk);
      rd(`IAF_OFS_CTRL, 8'h00);
      chk("pending", 48'h0, 48'(rd_q.size() + b_q.size() + er_q.size() + fw_q.size()));
      end_of_test();
   end
endmodule
